/* rtl/xcb_pkg.sv */
package xcb_pkg;

  // Machine cycle of three core clocks at 10 MHz
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLKS_PER_MCYC = 3;

  // Opcodes of the swap forms and the no-operation
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_SWAP_LO = 8'h55;
  localparam logic [7:0] OP_SWAP_FE = 8'h53;
  localparam logic [7:0] OP_SWAP_LONG = 8'h56;
  localparam logic [7:0] OP_WORD = 8'h57;

  // Opcode groups, low three bits select a bit or a form, or carry jump or call address bits
  localparam logic [4:0] G_BZERO = 5'h10;
  localparam logic [4:0] G_BONE = 5'h11;
  localparam logic [4:0] G_BCLR = 5'h12;
  localparam logic [4:0] G_CLR = 5'h13;
  localparam logic [4:0] G_INV = 5'h14;
  localparam logic [4:0] G_JUMP_A = 5'h16;
  localparam logic [4:0] G_JUMP_B = 5'h17;
  localparam logic [4:0] G_CALL = 5'h18;
  localparam logic [4:0] G_STAT = 5'h1c;
  localparam logic [4:0] G_POP = 5'h1d;

  // Fixed high address bytes of the short forms
  localparam logic [7:0] PAGE_LO = 8'h01;
  localparam logic [7:0] PAGE_FE = 8'hfe;
  localparam logic [7:0] PAGE_ZERO = 8'h00;

  // Status word bits and ninth data bit
  localparam int PSW_ONE = 1;
  localparam int PSW_THREE = 3;
  localparam int NINTH = 8;
  localparam logic [7:0] PSW_STAT_MASK = 8'h0a;

  // Reset values
  localparam logic [16:0] PC_RST = 17'h00000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [7:0] REG_RST = 8'h00;

  // Steps within an instruction: machine cycle times three plus phase
  localparam logic [3:0] STP_ISSUE = 4'h0;
  localparam logic [3:0] STP_DATA = 4'h2;
  localparam logic [3:0] STP_LOW_WR = 4'h3;
  localparam logic [3:0] STP_HIGH_WR = 4'h4;

  typedef enum logic [2:0] {
    PH_ADDR = 3'b001,
    PH_DATA = 3'b010,
    PH_WRITE = 3'b100
  } phase_t;

  typedef enum logic [3:0] {
    CL_NOP, CL_SWAP, CL_WORD, CL_BZERO, CL_BONE, CL_BCLR,
    CL_CLR, CL_INV, CL_JUMP, CL_CALL, CL_STAT, CL_POP
  } class_t;

  typedef struct packed {
    class_t cls;
    logic [1:0] len;
    logic [1:0] mcyc;
    logic bad;
  } decode_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [8:0] wdata;
  } mem_req_t;

endpackage

/* rtl/exch_branch_core.sv */
`timescale 1ns/1ps
// Overview of operation
// - Short byte swap exchanges A with direct location; length and time by address
// - Opcode 55H page 01xx, 53H page FExx, 56H with full address elsewhere
// - Byte swap with a nine-bit location also swaps status bit one and bit 8
// - Long byte swap 56H reaches any address, 3 bytes, 2 cycles
// - Word swap 57H is 3 bytes and 3 cycles
// - Word swap exchanges A with low byte and B with next byte
// - Word swap writes old status bit one into bit 8 of both bytes
// - Word swap loads status bit one from old bit 8 of high byte when that byte is a nine-bit location
// - Bit branches test a selected bit, one on zero, one on one
// - Branch-then-clear branches on the bit and clears it
// - Relative jump uses a 12-bit displacement from the program counter
// - Absolute call reaches any target in a 128K-byte bank
// - Status change forms touch only status bit one or bit three
// - Bit clear zeroes one selected bit, others unchanged
// - Bit invert flips one selected bit, others unchanged
// - No-operation takes one machine cycle, only the program counter moves
// - Byte pop reads the stack top into the addressed location
module exch_branch_core (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Program fetch window
  output logic [16:0] code_addr_r,
  input wire logic [23:0] code_bytes,
  // Data memory and special registers
  output xcb_pkg::mem_req_t mem_req_r,
  input wire logic [8:0] mem_rdata,
  input wire logic mem_has_ninth,
  // Architectural state
  output logic [7:0] acc_r,
  output logic [7:0] b_r,
  output logic [7:0] psw_r,
  output logic [15:0] sp_r,
  // Instruction events
  output logic retire_r,
  output logic illegal_r
);

  logic [7:0] op;
  logic [7:0] b1;
  logic [7:0] b2;
  xcb_pkg::decode_t dec;
  xcb_pkg::phase_t phase_r;
  logic [1:0] mcyc_r;
  logic [3:0] ph_idx;
  logic [3:0] step;
  logic last;
  logic [15:0] dst;
  logic [8:0] tmp_r;
  logic bit_set;
  logic [16:0] ret_pc;
  logic [16:0] pc_nxt;

  function automatic xcb_pkg::decode_t decode(input logic [7:0] code);
    xcb_pkg::decode_t d;
    d = '{cls: xcb_pkg::CL_NOP, len: 2'd1, mcyc: 2'd1, bad: 1'b0};
    case (code[7:3])
      xcb_pkg::G_BZERO: d = '{cls: xcb_pkg::CL_BZERO, len: 2'd3, mcyc: 2'd2, bad: 1'b0};
      xcb_pkg::G_BONE: d = '{cls: xcb_pkg::CL_BONE, len: 2'd3, mcyc: 2'd2, bad: 1'b0};
      xcb_pkg::G_BCLR: d = '{cls: xcb_pkg::CL_BCLR, len: 2'd3, mcyc: 2'd2, bad: 1'b0};
      xcb_pkg::G_CLR: d = '{cls: xcb_pkg::CL_CLR, len: 2'd3, mcyc: 2'd1, bad: 1'b0};
      xcb_pkg::G_INV: d = '{cls: xcb_pkg::CL_INV, len: 2'd3, mcyc: 2'd1, bad: 1'b0};
      xcb_pkg::G_JUMP_A, xcb_pkg::G_JUMP_B: d = '{cls: xcb_pkg::CL_JUMP, len: 2'd2, mcyc: 2'd1, bad: 1'b0};
      xcb_pkg::G_CALL: d = '{cls: xcb_pkg::CL_CALL, len: 2'd3, mcyc: 2'd3, bad: 1'b0};
      xcb_pkg::G_STAT: d = '{cls: xcb_pkg::CL_STAT, len: 2'd1, mcyc: 2'd1, bad: 1'b0};
      xcb_pkg::G_POP: d = '{cls: xcb_pkg::CL_POP, len: 2'd3, mcyc: 2'd2, bad: 1'b0};
      default: begin
        case (code)
          xcb_pkg::OP_NOP: d.bad = 1'b0;
          xcb_pkg::OP_SWAP_LO, xcb_pkg::OP_SWAP_FE: d = '{cls: xcb_pkg::CL_SWAP, len: 2'd2, mcyc: 2'd1, bad: 1'b0};
          xcb_pkg::OP_SWAP_LONG: d = '{cls: xcb_pkg::CL_SWAP, len: 2'd3, mcyc: 2'd2, bad: 1'b0};
          xcb_pkg::OP_WORD: d = '{cls: xcb_pkg::CL_WORD, len: 2'd3, mcyc: 2'd3, bad: 1'b0};
          default: d.bad = 1'b1;
        endcase
      end
    endcase
    return d;
  endfunction

  function automatic logic [7:0] bit_mask(input logic [2:0] n);
    return 8'h01 << n;
  endfunction

  // Code window is held stable while the program counter holds
  assign op = code_bytes[7:0];
  assign b1 = code_bytes[15:8];
  assign b2 = code_bytes[23:16];
  assign dec = decode(op);
  assign bit_set = tmp_r[op[2:0]];
  assign ret_pc = code_addr_r + 17'd3;

  always_comb begin
    case (op)
      xcb_pkg::OP_SWAP_LO: dst = {xcb_pkg::PAGE_LO, b1};
      xcb_pkg::OP_SWAP_FE: dst = {xcb_pkg::PAGE_FE, b1};
      default: dst = {b2, b1};
    endcase
    // Bit branches carry a displacement, so their operand sits in page zero
    if (dec.cls == xcb_pkg::CL_BZERO || dec.cls == xcb_pkg::CL_BONE || dec.cls == xcb_pkg::CL_BCLR) begin
      dst = {xcb_pkg::PAGE_ZERO, b1};
    end
  end

  always_comb begin
    case (phase_r)
      xcb_pkg::PH_DATA: ph_idx = 4'd1;
      xcb_pkg::PH_WRITE: ph_idx = 4'd2;
      default: ph_idx = 4'd0;
    endcase
    step = {2'b00, mcyc_r} * 4'(xcb_pkg::CLKS_PER_MCYC) + ph_idx;
  end

  // Instruction ends in the write phase of its final machine cycle
  assign last = (phase_r == xcb_pkg::PH_WRITE) && (mcyc_r == dec.mcyc - 2'd1);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase_r <= xcb_pkg::PH_ADDR;
      mcyc_r <= 2'd0;
    end else begin
      case (phase_r)
        xcb_pkg::PH_ADDR: phase_r <= xcb_pkg::PH_DATA;
        xcb_pkg::PH_DATA: phase_r <= xcb_pkg::PH_WRITE;
        xcb_pkg::PH_WRITE: begin
          phase_r <= xcb_pkg::PH_ADDR;
          mcyc_r <= last ? 2'd0 : mcyc_r + 2'd1;
        end
        default: begin
          phase_r <= xcb_pkg::PH_ADDR;
          mcyc_r <= 2'd0;
        end
      endcase
    end
  end

  always_comb begin
    pc_nxt = code_addr_r + {15'd0, dec.len};
    case (dec.cls)
      xcb_pkg::CL_BZERO: begin
        if (!bit_set) begin
          pc_nxt = pc_nxt + {{9{b2[7]}}, b2};
        end
      end
      xcb_pkg::CL_BONE, xcb_pkg::CL_BCLR: begin
        if (bit_set) begin
          pc_nxt = pc_nxt + {{9{b2[7]}}, b2};
        end
      end
      xcb_pkg::CL_JUMP: pc_nxt = pc_nxt + {{5{op[3]}}, op[3:0], b1};
      xcb_pkg::CL_CALL: pc_nxt = {op[0], b2, b1};
      default: pc_nxt = pc_nxt;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      code_addr_r <= xcb_pkg::PC_RST;
    end else if (last) begin
      code_addr_r <= pc_nxt;
    end
  end

  // Low byte or tested byte, kept for later steps
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tmp_r <= 9'h000;
    end else if (step == xcb_pkg::STP_DATA) begin
      tmp_r <= mem_rdata;
    end
  end

  // Read data is valid two steps after the request is registered
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mem_req_r <= '0;
    end else begin
      mem_req_r <= '0;
      case (dec.cls)
        xcb_pkg::CL_SWAP, xcb_pkg::CL_CLR, xcb_pkg::CL_INV, xcb_pkg::CL_BCLR, xcb_pkg::CL_WORD,
        xcb_pkg::CL_BZERO, xcb_pkg::CL_BONE: begin
          if (step == xcb_pkg::STP_ISSUE) begin
            mem_req_r.rd <= 1'b1;
            mem_req_r.addr <= dst;
          end
          if (step == xcb_pkg::STP_DATA) begin
            mem_req_r.addr <= dst;
            mem_req_r.wr <= 1'b1;
            mem_req_r.wdata <= mem_rdata;
            case (dec.cls)
              xcb_pkg::CL_SWAP: mem_req_r.wdata <= {psw_r[xcb_pkg::PSW_ONE], acc_r};
              xcb_pkg::CL_CLR, xcb_pkg::CL_BCLR: begin
                mem_req_r.wdata[7:0] <= mem_rdata[7:0] & ~bit_mask(op[2:0]);
              end
              xcb_pkg::CL_INV: mem_req_r.wdata[7:0] <= mem_rdata[7:0] ^ bit_mask(op[2:0]);
              xcb_pkg::CL_WORD: begin
                mem_req_r.wr <= 1'b0;
                mem_req_r.rd <= 1'b1;
                mem_req_r.addr <= dst + 16'd1;
              end
              default: mem_req_r.wr <= 1'b0;
            endcase
          end
          if (dec.cls == xcb_pkg::CL_WORD && step == xcb_pkg::STP_LOW_WR) begin
            mem_req_r.wr <= 1'b1;
            mem_req_r.addr <= dst;
            mem_req_r.wdata <= {psw_r[xcb_pkg::PSW_ONE], acc_r};
          end
          if (dec.cls == xcb_pkg::CL_WORD && step == xcb_pkg::STP_HIGH_WR) begin
            mem_req_r.wr <= 1'b1;
            mem_req_r.addr <= dst + 16'd1;
            mem_req_r.wdata <= {psw_r[xcb_pkg::PSW_ONE], b_r};
          end
        end
        xcb_pkg::CL_CALL: begin
          // Bank bit of the return address rides in the ninth bit
          if (step == xcb_pkg::STP_ISSUE) begin
            mem_req_r.wr <= 1'b1;
            mem_req_r.addr <= sp_r + 16'd1;
            mem_req_r.wdata <= {1'b0, ret_pc[7:0]};
          end
          if (step == xcb_pkg::STP_LOW_WR) begin
            mem_req_r.wr <= 1'b1;
            mem_req_r.addr <= sp_r + 16'd2;
            mem_req_r.wdata <= ret_pc[16:8];
          end
        end
        xcb_pkg::CL_POP: begin
          if (step == xcb_pkg::STP_ISSUE) begin
            mem_req_r.rd <= 1'b1;
            mem_req_r.addr <= sp_r;
          end
          if (step == xcb_pkg::STP_DATA) begin
            mem_req_r.wr <= 1'b1;
            mem_req_r.addr <= dst;
            mem_req_r.wdata <= mem_rdata;
          end
        end
        default: mem_req_r <= '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_r <= xcb_pkg::REG_RST;
    end else if (dec.cls == xcb_pkg::CL_SWAP && step == xcb_pkg::STP_DATA) begin
      acc_r <= mem_rdata[7:0];
    end else if (dec.cls == xcb_pkg::CL_WORD && step == xcb_pkg::STP_LOW_WR) begin
      acc_r <= tmp_r[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      b_r <= xcb_pkg::REG_RST;
    end else if (dec.cls == xcb_pkg::CL_WORD && step == xcb_pkg::STP_HIGH_WR) begin
      b_r <= mem_rdata[7:0];
    end
  end

  // An eight-bit location has no ninth bit to give back
  always_ff @(posedge core_clk) begin
    if (srst) begin
      psw_r <= xcb_pkg::REG_RST;
    end else if (dec.cls == xcb_pkg::CL_SWAP && step == xcb_pkg::STP_DATA && mem_has_ninth) begin
      psw_r[xcb_pkg::PSW_ONE] <= mem_rdata[xcb_pkg::NINTH];
    end else if (dec.cls == xcb_pkg::CL_WORD && step == xcb_pkg::STP_HIGH_WR && mem_has_ninth) begin
      psw_r[xcb_pkg::PSW_ONE] <= mem_rdata[xcb_pkg::NINTH];
    end else if (dec.cls == xcb_pkg::CL_STAT && step == xcb_pkg::STP_ISSUE) begin
      if (op[1]) begin
        psw_r[xcb_pkg::PSW_THREE] <= op[0];
      end else begin
        psw_r[xcb_pkg::PSW_ONE] <= op[0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sp_r <= xcb_pkg::SP_RST;
    end else if (dec.cls == xcb_pkg::CL_CALL && step == xcb_pkg::STP_LOW_WR) begin
      sp_r <= sp_r + 16'd2;
    end else if (dec.cls == xcb_pkg::CL_POP && step == xcb_pkg::STP_DATA) begin
      sp_r <= sp_r - 16'd1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      retire_r <= 1'b0;
      illegal_r <= 1'b0;
    end else begin
      retire_r <= last;
      illegal_r <= last && dec.bad;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  a_swap_short_len: assert property ((last && (op == 8'h55 || op == 8'h53)) |=>
    code_addr_r == $past(code_addr_r) + 17'd2) else $error("short swap length wrong");

  a_swap_short_time: assert property ((step == 4'd0 && op == 8'h55) |-> ##2 last)
    else $error("short swap not one machine cycle");

  a_long_swap_time: assert property ((step == 4'd0 && op == 8'h56) |-> (!last) [*5] ##1 last)
    else $error("long swap not two machine cycles");

  a_word_swap_time: assert property ((step == 4'd0 && op == 8'h57) |-> (!last) [*8] ##1 last
    ##1 code_addr_r == $past(code_addr_r) + 17'd3) else $error("word swap timing or length wrong");

  a_word_swap_regs: assert property ((dec.cls == xcb_pkg::CL_WORD && step == 4'd3) |=>
    acc_r == $past(tmp_r[7:0]) ##1 b_r == $past(mem_rdata[7:0])) else $error("word swap data wrong");

  a_word_ninth_out: assert property ((dec.cls == xcb_pkg::CL_WORD && step == 4'd3) |=>
    mem_req_r.wr && mem_req_r.wdata[8] == $past(psw_r[1]) ##1 mem_req_r.wr && mem_req_r.wdata[8] == $past(psw_r[1], 2))
    else $error("word swap ninth bits wrong");

  a_word_flag_in: assert property ((dec.cls == xcb_pkg::CL_WORD && step == 4'd4) |=>
    psw_r[1] == ($past(mem_has_ninth) ? $past(mem_rdata[8]) : $past(psw_r[1]))) else $error("word flag load wrong");

  a_swap_ninth: assert property ((dec.cls == xcb_pkg::CL_SWAP && step == 4'd2) |=> mem_req_r.wr
    && mem_req_r.wdata == {$past(psw_r[1]), $past(acc_r)}
    && psw_r[1] == ($past(mem_has_ninth) ? $past(mem_rdata[8]) : $past(psw_r[1]))) else $error("swap ninth bit wrong");

  a_bit_clear: assert property ((dec.cls == xcb_pkg::CL_CLR && step == 4'd2) |=>
    mem_req_r.wdata == ($past(mem_rdata) & ~{1'b0, bit_mask($past(op[2:0]))})) else $error("bit clear wrong");

  a_bit_invert: assert property ((dec.cls == xcb_pkg::CL_INV && step == 4'd2) |=>
    mem_req_r.wdata == ($past(mem_rdata) ^ {1'b0, bit_mask($past(op[2:0]))})) else $error("bit invert wrong");

  a_status_only: assert property ((dec.cls == xcb_pkg::CL_STAT && step == 4'd0) |=>
    (psw_r & ~xcb_pkg::PSW_STAT_MASK) == ($past(psw_r) & ~xcb_pkg::PSW_STAT_MASK))
    else $error("status change touched other bits");

  a_nop_quiet: assert property ((step == 4'd0 && op == 8'h00) |-> ##2 last ##1
    (code_addr_r == $past(code_addr_r) + 17'd1 && acc_r == $past(acc_r, 3) && psw_r == $past(psw_r, 3)))
    else $error("nop changed state");

  a_jump_disp: assert property ((last && dec.cls == xcb_pkg::CL_JUMP) |=>
    code_addr_r == $past(code_addr_r) + 17'd2 + {{5{$past(op[3])}}, $past(op[3:0]), $past(b1)})
    else $error("relative jump target wrong");

  c_word_swap: cover property (dec.cls == xcb_pkg::CL_WORD && last);
  c_swap_ninth: cover property (dec.cls == xcb_pkg::CL_SWAP && step == 4'd2 && mem_has_ninth);
  c_branch_taken: cover property (last && dec.cls == xcb_pkg::CL_BONE && bit_set);
  c_call: cover property (last && dec.cls == xcb_pkg::CL_CALL);

endmodule // exch_branch_core

/* bench/data_mem_model.sv */
`timescale 1ns/1ps
module data_mem_model (
  // Clock
  input wire logic core_clk,
  // Core side
  input wire xcb_pkg::mem_req_t mem_req,
  output logic [8:0] mem_rdata,
  output logic mem_has_ninth
);
  logic [8:0] mem [0:65535];

  // Low 512 bytes carry a ninth bit, the rest are plain bytes
  function automatic logic nin(input logic [15:0] a);
    return a < 16'h0200;
  endfunction

  initial begin
    mem_rdata = '0;
    mem_has_ninth = 1'b0;
  end

  // Idle cycles scramble read data so a stale value never passes
  always @(posedge core_clk) begin
    if (mem_req.rd) begin
      mem_rdata <= mem[mem_req.addr];
      mem_has_ninth <= nin(mem_req.addr);
    end else begin
      mem_rdata <= ~mem_rdata;
      mem_has_ninth <= ~mem_has_ninth;
    end
    if (mem_req.wr) begin
      mem[mem_req.addr] <= nin(mem_req.addr) ? mem_req.wdata : {1'b0, mem_req.wdata[7:0]};
    end
  end
endmodule // data_mem_model

/* bench/cpu_exchange_and_branch_ops_test.sv */
`timescale 1ns/1ps
module cpu_exchange_and_branch_ops_test;
  typedef struct {
    logic [16:0] pc;
    logic [7:0] a, b, program_status_word;
    logic [15:0] sp;
    logic ill;
    int cy;
    logic [15:0] ma0, ma1;
    logic [8:0] mv0, mv1;
    string fin;
  } note_t;

  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [23:0] code_bytes = '0;
  logic [16:0] code_addr_r;
  xcb_pkg::mem_req_t mem_req_r;
  logic [8:0] mem_rdata;
  logic mem_has_ninth;
  logic [7:0] acc_r, b_r, psw_r;
  logic [15:0] sp_r;
  logic retire_r, illegal_r;
  logic [7:0] rom [0:131071];
  logic [8:0] em [0:65535];
  logic [16:0] e_pc = '0;
  logic [7:0] e_a = '0, e_b = '0, e_psw = '0;
  logic [15:0] e_sp = '0;
  logic [31:0] seed = 32'ha835bfdf;
  note_t q[$];
  note_t pend;
  logic pend_v = 1'b0;
  int n_mismatch = 0, check_count = 0, cnt = -1;

  always #(xcb_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  exch_branch_core exch_branch_core_i (.core_clk(core_clk), .srst(srst), .code_addr_r(code_addr_r),
    .code_bytes(code_bytes), .mem_req_r(mem_req_r), .mem_rdata(mem_rdata), .mem_has_ninth(mem_has_ninth),
    .acc_r(acc_r), .b_r(b_r), .psw_r(psw_r), .sp_r(sp_r), .retire_r(retire_r), .illegal_r(illegal_r));
  data_mem_model data_mem_model_i (.core_clk(core_clk), .mem_req(mem_req_r), .mem_rdata(mem_rdata),
    .mem_has_ninth(mem_has_ninth));

  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic nin(input logic [15:0] a);
    return a < 16'h0200;
  endfunction

  task automatic wr(input logic [15:0] a, input logic [8:0] v);
    em[a] = nin(a) ? v : {1'b0, v[7:0]};
  endtask

  // Places one instruction and notes the state expected at its retire
  task automatic op(input logic [7:0] o, input logic [7:0] l, input logic [7:0] h);
    note_t n;
    logic [15:0] ad;
    logic [8:0] d;
    logic [8:0] e;
    logic [16:0] t;
    int ln;
    logic [2:0] k;
    ln = 1;
    n.cy = 1;
    n.ill = 1'b0;
    ad = {h, l};
    k = o[2:0];
    rom[e_pc] = o;
    rom[e_pc + 17'd1] = l;
    rom[e_pc + 17'd2] = h;
    if (o inside {8'h53, 8'h55, 8'h56}) begin
      ln = (o == 8'h56) ? 3 : 2;
      n.cy = ln - 1;
      if (o == 8'h55) ad[15:8] = 8'h01;
      if (o == 8'h53) ad[15:8] = 8'hfe;
      d = em[ad];
      wr(ad, {e_psw[1], e_a});
      e_a = d[7:0];
      if (nin(ad)) e_psw[1] = d[8];
    end else if (o == 8'h57) begin
      d = em[ad];
      e = em[ad + 16'd1];
      wr(ad, {e_psw[1], e_a});
      wr(ad + 16'd1, {e_psw[1], e_b});
      e_a = d[7:0];
      e_b = e[7:0];
      if (nin(ad + 16'd1)) e_psw[1] = e[8];
      ln = 3;
      n.cy = 3;
    end else if (o[7:3] == 5'h13 || o[7:3] == 5'h14) begin
      ln = 3;
      em[ad][k] = (o[7:3] == 5'h14) ? ~em[ad][k] : 1'b0;
    end else if (o[7:5] == 3'b100) begin
      ad = {8'h00, l};
      d = em[ad];
      ln = 3;
      n.cy = 2;
      t = e_pc + 17'd3 + {{9{h[7]}}, h};
      if (o[4]) em[ad][k] = 1'b0;
      if (d[k] == (o[4] | o[3])) begin
        e_pc = t;
        ln = 0;
      end
    end else if (o[7:4] == 4'hb) begin
      e_pc = e_pc + 17'd2 + {{5{o[3]}}, o[3:0], l};
      ln = 0;
    end else if (o[7:1] == 7'h60) begin
      t = e_pc + 17'd3;
      wr(e_sp + 16'd1, {1'b0, t[7:0]});
      ad = e_sp + 16'd2;
      wr(ad, {t[16], t[15:8]});
      e_sp = ad;
      e_pc = {o[0], h, l};
      ln = 0;
      n.cy = 3;
    end else if (o[7:3] == 5'h1c) begin
      if (o[1]) e_psw[3] = o[0];
      else e_psw[1] = o[0];
    end else if (o[7:3] == 5'h1d) begin
      wr(ad, em[e_sp]);
      e_sp = e_sp - 16'd1;
      ln = 3;
      n.cy = 2;
    end else if (o != 8'h00) begin
      n.ill = 1'b1;
    end
    e_pc = e_pc + 17'(ln);
    n.pc = e_pc;
    n.a = e_a;
    n.b = e_b;
    n.program_status_word = e_psw;
    n.sp = e_sp;
    n.ma0 = ad;
    n.ma1 = (o == 8'h57) ? ad + 16'd1 : ad;
    n.mv0 = em[n.ma0];
    n.mv1 = em[n.ma1];
    n.fin = "";
    q.push_back(n);
  endtask

  task automatic mark(input string s);
    q[$].fin = s;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Fetch window follows the program counter, refreshed off the sampling edge
  always @(negedge core_clk) begin
    code_bytes <= {rom[code_addr_r + 17'd2], rom[code_addr_r + 17'd1], rom[code_addr_r]};
  end

  // Memory lands one cycle after retire at the latest, so it is checked then
  always @(negedge core_clk) begin
    if (pend_v) begin
      check_count++;
      if (data_mem_model_i.mem[pend.ma0] !== pend.mv0 ||
          data_mem_model_i.mem[pend.ma1] !== pend.mv1) begin
        $display("CHECK FAILED %0t memory at %h", $time, pend.ma0);
        n_mismatch++;
      end
      if (pend.fin != "") $display("%s test done", pend.fin);
      pend_v = 1'b0;
    end
    if (cnt >= 0) cnt++;
    if (retire_r === 1'b1 && q.size() > 0) begin
      pend = q.pop_front();
      pend_v = 1'b1;
      check_count += 3;
      if ({code_addr_r, acc_r, b_r, psw_r, sp_r} !==
          {pend.pc, pend.a, pend.b, pend.program_status_word, pend.sp}) begin
        $display("CHECK FAILED %0t state pc %h want %h", $time, code_addr_r, pend.pc);
        n_mismatch++;
      end
      if (illegal_r !== pend.ill) begin
        $display("CHECK FAILED %0t undefined opcode flag", $time);
        n_mismatch++;
      end
      if (cnt > 0 && cnt != xcb_pkg::CLKS_PER_MCYC * pend.cy) begin
        $display("CHECK FAILED %0t took %0d clocks", $time, cnt);
        n_mismatch++;
      end
      cnt = 0;
    end
  end

  initial begin
    logic [31:0] v;
    logic [16:0] t;
    for (int i = 0; i < 131072; i++) begin
      rom[i] = 8'h00;
      v = xs();
      if (i < 65536) wr(16'(i), v[8:0]);
      if (i < 65536) data_mem_model_i.mem[i] = em[i];
    end
    for (int i = 0; i < 8; i++) op(8'he0 + 8'(i), 8'h00, 8'h00);
    mark("status");
    v = xs();
    op(8'h55, v[7:0], 8'h00);
    op(8'h53, v[15:8], 8'h00);
    op(8'h56, 8'hff, 8'h00);
    op(8'h56, 8'h00, 8'h03);
    op(8'h56, v[23:16], 8'hff);
    mark("byte swap");
    op(8'h57, 8'h10, 8'h00);
    op(8'h57, 8'hff, 8'h01);
    mark("word swap");
    op(8'h00, 8'h57, 8'h57);
    op(8'h54, 8'h00, 8'h00);
    mark("nop");
    for (int n = 0; n < 8; n++) begin
      v = xs();
      op(8'h98 + 8'(n), v[7:0], {7'h00, v[8]});
      op(8'ha0 + 8'(n), v[7:0], 8'hfe);
      op(8'h80 + 8'(n), v[15:8], {4'h0, v[19:16]});
      op(8'h88 + 8'(n), v[15:8], {4'h0, v[23:20]});
      op(8'h90 + 8'(n), v[15:8], {4'h0, v[27:24]});
      op(8'hb0 + 8'(v[28]), v[7:0], 8'h00);
    end
    mark("bit");
    t = e_pc + 17'h10000;
    op({7'h60, t[16]}, t[7:0], t[15:8]);
    op(8'he8, 8'h50, 8'h01);
    op(8'he8 + 8'(v[2:0]), v[15:8], 8'hfe);
    // Backward jump lands in the unused space below the call target
    op(8'hbf, 8'hf0, 8'h00);
    op(8'hb0, 8'h40, 8'h00);
    mark("call, pop and jump");
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    for (int i = 0; i < 20000 && (q.size() > 0 || pend_v); i++) @(negedge core_clk);
    if (q.size() > 0 || pend_v) begin
      $display("CHECK FAILED %0t instruction stream stalled", $time);
      n_mismatch++;
    end
    summarize();
  end
endmodule // cpu_exchange_and_branch_ops_test
